// File: hw/led_exp_dev.sv
// expander end: serial slave, register file, blinkers and drivers
`timescale 1ns/100ps
`default_nettype none
`include "led_exp_consts.svh"
module led_exp_dev #(
  parameter int unsigned BLINK_STEP_CYC = `BLINK_STEP_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  led_link_if.dev          link,
  input  wire logic        ext_reset_n,
  input  wire logic        slave_select_pin_low,
  input  wire logic        slave_select_pin_mid,
  input  wire logic        slave_select_pin_high,
  input  wire logic [15:0] open_drain_driver_pins_in,
  output logic      [15:0] open_drain_driver_pins_oe
);
  localparam led_exp_pkg::dev_reg_t DEV_RST = '{
    st: led_exp_pkg::DEV_IDLE, psc0: `PSC_RST, pwm0: `PWM_RST, psc1: `PSC_RST,
    pwm1: `PWM_RST, output_state_selector: `LS_RST, scl_p: 1'h1, sda_p: 1'h1,
    default: '0};

  led_exp_pkg::dev_reg_t q;
  led_exp_pkg::dev_reg_t nxt;
  logic                  scl_f;
  logic                  sda_f;
  logic [15:0]           next_led_oe;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  start_seen;
  logic                  stop_seen;
  logic                  addr_hit;
  logic                  tick;

  line_filter u_scl_filt (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .raw     (link.scl),
    .clean   (scl_f)
  );
  line_filter u_sda_filt (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .raw     (link.sda),
    .clean   (sda_f)
  );

  // bus events from filtered lines against their last values
  // data change under high clock is a condition
  // start is falling data with clock high
  // stop is rising data with clock high
  assign scl_rise   = scl_f & !q.scl_p;
  assign scl_fall   = !scl_f & q.scl_p;
  assign start_seen = scl_f & q.scl_p & q.sda_p & !sda_f;
  assign stop_seen  = scl_f & q.scl_p & !q.sda_p & sda_f;
  // fixed upper bits then the select pins
  assign addr_hit   = q.shreg[7:1] == {`ADDR_FIXED, q.sel_s2};
  assign tick       = q.tick_cnt == `BLINK_W'(BLINK_STEP_CYC - 1);

  genvar i;
  generate
    for (i = 0; i < `LED_COUNT; i++)
    begin : g_led
      logic [1:0] sel;
      assign sel = q.output_state_selector[2*i+1:2*i];
      assign next_led_oe[i] = (sel == `SEL_LOW) | ((sel == `SEL_FIRST_BLINK_WAVEFORM) & q.first_blink_waveform)
                            | ((sel == `SEL_SECOND_BLINK_WAVEFORM) & q.second_blink_waveform);
    end
  endgenerate

  // pointer steps only when asked, wrapping after the last
  function automatic logic [3:0] step_ptr(input logic [3:0] p, input logic en);
    if (!en)
      return p;
    else if (p == `REG_LAST)
      return 4'h0;
    else
      return p + 4'h1;
  endfunction

  // register read mux; unmapped pointers read zero
  function automatic logic [7:0] rd_mux(input led_exp_pkg::dev_reg_t s);
    case (s.register_pointer_bits)
      // pin levels whatever the selector says
      `REG_INPUT0: return s.led_s2[7:0];
      `REG_INPUT1: return s.led_s2[15:8];
      `REG_PSC0:   return s.psc0;
      `REG_PWM0:   return s.pwm0;
      `REG_PSC1:   return s.psc1;
      `REG_PWM1:   return s.pwm1;
      `REG_LS0:    return s.output_state_selector[7:0];
      `REG_LS1:    return s.output_state_selector[15:8];
      `REG_LS2:    return s.output_state_selector[23:16];
      `REG_LS3:    return s.output_state_selector[31:24];
      default:     return 8'h00;
    endcase
  endfunction

  // one blinker: prescale the step tick, then run the duty counter
  function automatic logic [15:0] blink_adv(input logic [7:0] pc, input logic [7:0] bc,
                                            input logic [7:0] psc);
    if (pc == psc)
      return {8'h00, bc + 8'h01};
    else
      return {pc + 8'h01, bc};
  endfunction

  // next state of everything
  always_comb
  begin
    nxt = q;
    nxt.rstn_s1 = ext_reset_n;
    nxt.rstn_s2 = q.rstn_s1;
    nxt.led_s1 = open_drain_driver_pins_in;
    nxt.led_s2 = q.led_s1;
    nxt.sel_s1 = {slave_select_pin_high, slave_select_pin_mid, slave_select_pin_low};
    nxt.sel_s2 = q.sel_s1;
    nxt.scl_p = scl_f;
    nxt.sda_p = sda_f;
    nxt.led_oe = next_led_oe;
    // blinkers: output low phase while duty counter under the limit
    nxt.tick_cnt = tick ? '0 : q.tick_cnt + 15'h0001;
    if (tick)
    begin
      {nxt.pc0, nxt.bc0} = blink_adv(q.pc0, q.bc0, q.psc0);
      {nxt.pc1, nxt.bc1} = blink_adv(q.pc1, q.bc1, q.psc1);
    end
    nxt.first_blink_waveform = q.bc0 < q.pwm0;
    nxt.second_blink_waveform = q.bc1 < q.pwm1;
    // any start or stop drops the partial byte
    if (start_seen)
    begin
      nxt.st = led_exp_pkg::DEV_RX;
      nxt.bitcnt = 4'h0;
      nxt.is_addr = 1'h1;
      nxt.sda_oe = 1'h0;
    end
    else if (stop_seen)
    begin
      nxt.st = led_exp_pkg::DEV_IDLE;
      nxt.sda_oe = 1'h0;
    end
    else
    begin
      // all shifting paced by serial clock edges
      case (q.st)
        // nothing but a start leaves idle
        led_exp_pkg::DEV_IDLE: nxt.sda_oe = 1'h0;
        led_exp_pkg::DEV_RX:
        begin
          if (scl_rise)
          begin
            nxt.shreg = {q.shreg[6:0], sda_f};
            nxt.bitcnt = q.bitcnt + 4'h1;
          end
          else if (scl_fall && q.bitcnt == `BIT_LAST)
          begin
            // acknowledge after the eighth bit falls
            nxt.st = led_exp_pkg::DEV_ACK;
            nxt.sda_oe = 1'h1;
            nxt.is_addr = 1'h0;
            if (q.is_addr)
            begin
              nxt.rd = q.shreg[0] == `RW_READ;
              nxt.is_ptr = q.shreg[0] == `RW_WRITE;
              if (!addr_hit)
              begin
                nxt.st = led_exp_pkg::DEV_IDLE;
                nxt.sda_oe = 1'h0;
              end
            end
            // first written byte is the pointer
            else if (q.is_ptr)
            begin
              nxt.is_ptr = 1'h0;
              nxt.register_pointer_bits = q.shreg[3:0];
              nxt.pointer_step_flag = q.shreg[`STEP_BIT];
            end
            else
            begin
              case (q.register_pointer_bits)
                `REG_PSC0: nxt.psc0 = q.shreg;
                `REG_PWM0:
                begin
                  nxt.pwm0 = q.shreg;
                  nxt.bc0 = 8'h00;
                end
                `REG_PSC1: nxt.psc1 = q.shreg;
                `REG_PWM1:
                begin
                  nxt.pwm1 = q.shreg;
                  nxt.bc1 = 8'h00;
                end
                `REG_LS0: nxt.output_state_selector[7:0] = q.shreg;
                `REG_LS1: nxt.output_state_selector[15:8] = q.shreg;
                `REG_LS2: nxt.output_state_selector[23:16] = q.shreg;
                `REG_LS3: nxt.output_state_selector[31:24] = q.shreg;
                default: ; // input registers ignore writes, still acked
              endcase
              nxt.register_pointer_bits = step_ptr(q.register_pointer_bits, q.pointer_step_flag);
            end
          end
        end
        led_exp_pkg::DEV_ACK:
        begin
          if (scl_fall)
          begin
            nxt.bitcnt = 4'h0;
            nxt.st = led_exp_pkg::DEV_RX;
            nxt.sda_oe = 1'h0;
            if (q.rd)
            begin
              // inputs are sampled here, on the ack falling edge
              nxt.st = led_exp_pkg::DEV_TX;
              nxt.shreg = rd_mux(q);
              nxt.sda_oe = !nxt.shreg[7];
              nxt.register_pointer_bits = step_ptr(q.register_pointer_bits, q.pointer_step_flag);
            end
          end
        end
        led_exp_pkg::DEV_TX:
        begin
          if (scl_fall)
          begin
            nxt.bitcnt = q.bitcnt + 4'h1;
            nxt.shreg = {q.shreg[6:0], 1'h0};
            // a one is sent by releasing the line
            nxt.sda_oe = !q.shreg[6];
            if (q.bitcnt == `BIT_LAST - 4'h1)
            begin
              nxt.st = led_exp_pkg::DEV_TXACK;
              nxt.sda_oe = 1'h0;
            end
          end
        end
        led_exp_pkg::DEV_TXACK:
        begin
          if (scl_rise)
            nxt.mack = !sda_f;
          else if (scl_fall)
          begin
            // no ack from the master: go quiet until stop or start
            nxt.st = led_exp_pkg::DEV_IDLE;
            if (q.mack)
            begin
              nxt.st = led_exp_pkg::DEV_TX;
              nxt.bitcnt = 4'h0;
              nxt.shreg = rd_mux(q);
              nxt.sda_oe = !nxt.shreg[7];
              nxt.register_pointer_bits = step_ptr(q.register_pointer_bits, q.pointer_step_flag);
            end
          end
        end
        default: nxt.st = led_exp_pkg::DEV_IDLE;
      endcase
    end
    // reset pin puts bus logic back to idle
    // registers pinned to defaults while it stays low
    if (!q.rstn_s2)
    begin
      nxt.st = led_exp_pkg::DEV_IDLE;
      nxt.sda_oe = 1'h0;
      nxt.register_pointer_bits = 4'h0;
      nxt.pointer_step_flag = 1'h0;
      nxt.psc0 = `PSC_RST;
      nxt.pwm0 = `PWM_RST;
      nxt.psc1 = `PSC_RST;
      nxt.pwm1 = `PWM_RST;
      nxt.output_state_selector = `LS_RST;
      nxt.bc0 = 8'h00;
      nxt.bc1 = 8'h00;
      nxt.pc0 = 8'h00;
      nxt.pc1 = 8'h00;
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      q <= DEV_RST;
    else
      q <= nxt;
  end

  // open-drain: enable only ever pulls low
  assign link.sda_dev_oe = q.sda_oe;
  assign open_drain_driver_pins_oe = q.led_oe;
endmodule
`default_nettype wire

// File: hw/led_exp_consts.svh
// shared constants for the led expander serial link
`ifndef LED_EXP_CONSTS_SVH
`define LED_EXP_CONSTS_SVH
`define SYS_CLK_MHZ 250
`define FILT_NS 100
// least time, so rounded up to whole cycles
`define FILT_CYC ((`FILT_NS * `SYS_CLK_MHZ + 999) / 1000)
`define FILT_W 5
`define LED_COUNT 16
`define ADDR_FIXED 4'hC
`define RW_READ 1'h1
`define RW_WRITE 1'h0
`define BIT_LAST 4'h8
`define STEP_BIT 4
// 44 blink periods per second, 256 duty steps each
`define BLINK_DIV_HZ 11264
`define BLINK_STEP_CYC ((`SYS_CLK_MHZ * 1000000) / `BLINK_DIV_HZ)
`define BLINK_W 15
`define REG_INPUT0 4'h0
`define REG_INPUT1 4'h1
`define REG_PSC0 4'h2
`define REG_PWM0 4'h3
`define REG_PSC1 4'h4
`define REG_PWM1 4'h5
`define REG_LS0 4'h6
`define REG_LS1 4'h7
`define REG_LS2 4'h8
`define REG_LS3 4'h9
`define REG_LAST 4'h9
`define PSC_RST 8'hFF
`define PWM_RST 8'h80
`define LS_RST 32'h55555555
`define SEL_LOW 2'h0
`define SEL_OFF 2'h1
`define SEL_FIRST_BLINK_WAVEFORM 2'h2
`define SEL_SECOND_BLINK_WAVEFORM 2'h3
`define HOST_QTR_NS 700
`define HOST_QTR_CYC ((`HOST_QTR_NS * `SYS_CLK_MHZ + 999) / 1000)
`define HOST_QTR_W 8
`define BSEL_ADDR_WR 3'h0
`define BSEL_PTR 3'h1
`define BSEL_DATA 3'h2
`define BSEL_ADDR_RD 3'h3
`define BSEL_RX 3'h4
`endif

// File: hw/led_exp_pkg.sv
// types for the led expander link ends
`default_nettype none
package led_exp_pkg;
  typedef enum logic [4:0] {
    DEV_IDLE  = 5'h01,
    DEV_RX    = 5'h02,
    DEV_ACK   = 5'h04,
    DEV_TX    = 5'h08,
    DEV_TXACK = 5'h10
  } dev_state_t;
  typedef enum logic [4:0] {
    H_IDLE    = 5'h01,
    H_START   = 5'h02,
    H_BIT     = 5'h04,
    H_RESTART = 5'h08,
    H_STOP    = 5'h10
  } host_state_t;
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       clean;
    logic [4:0] cnt;
  } filt_reg_t;
  typedef struct packed {
    dev_state_t  st;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic        is_addr;
    logic        is_ptr;
    logic        rd;
    logic        mack;
    logic [3:0]  register_pointer_bits;
    logic        pointer_step_flag;
    logic [7:0]  psc0;
    logic [7:0]  pwm0;
    logic [7:0]  psc1;
    logic [7:0]  pwm1;
    logic [31:0] output_state_selector;
    logic        scl_p;
    logic        sda_p;
    logic        sda_oe;
    logic [15:0] led_oe;
    logic [15:0] led_s1;
    logic [15:0] led_s2;
    logic [2:0]  sel_s1;
    logic [2:0]  sel_s2;
    logic        rstn_s1;
    logic        rstn_s2;
    logic [14:0] tick_cnt;
    logic [7:0]  pc0;
    logic [7:0]  bc0;
    logic [7:0]  pc1;
    logic [7:0]  bc1;
    logic        first_blink_waveform;
    logic        second_blink_waveform;
  } dev_reg_t;
  typedef struct packed {
    host_state_t st;
    logic [1:0]  ph;
    logic [7:0]  qcnt;
    logic [3:0]  bi;
    logic [2:0]  bsel;
    logic        rw;
    logic [2:0]  dsel;
    logic [7:0]  ptr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        nack;
    logic        scl_oe;
    logic        sda_oe;
    logic        sda_s1;
    logic        sda_s2;
    logic        cmd_ready;
    logic        rsp_valid;
  } host_reg_t;
endpackage
`default_nettype wire

// File: hw/led_link_if.sv
// two-wire link between the host end and the expander end
`timescale 1ns/100ps
`default_nettype none
interface led_link_if;
  logic scl_host_oe;
  logic sda_host_oe;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  // open-drain wires with pull-up: any enable pulls low
  assign scl = !scl_host_oe;
  assign sda = !(sda_host_oe | sda_dev_oe);
  modport host (output scl_host_oe, output sda_host_oe, input scl, input sda);
  modport dev (output sda_dev_oe, input scl, input sda);
endinterface
`default_nettype wire

// File: hw/line_filter.sv
// two-flop synchroniser and glitch filter for one bus line
`timescale 1ns/100ps
`default_nettype none
`include "led_exp_consts.svh"
module line_filter (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic raw,
  output logic      clean
);
  led_exp_pkg::filt_reg_t q;
  led_exp_pkg::filt_reg_t nxt;

  // a change must outlast the glitch window before it is taken
  always_comb
  begin
    nxt = q;
    nxt.s1 = raw;
    nxt.s2 = q.s1;
    if (q.s2 == q.clean)
      nxt.cnt = '0;
    else if (q.cnt == `FILT_W'(`FILT_CYC))
    begin
      nxt.clean = q.s2;
      nxt.cnt = '0;
    end
    else
      nxt.cnt = q.cnt + 5'h01;
  end

  // idle bus reads high
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      q <= '{s1: 1'h1, s2: 1'h1, clean: 1'h1, cnt: 5'h00};
    else
      q <= nxt;
  end

  assign clean = q.clean;
endmodule
`default_nettype wire

// File: hw/led_exp_host.sv
// host end: bus master issuing one-byte register writes and reads
`timescale 1ns/100ps
`default_nettype none
`include "led_exp_consts.svh"
module led_exp_host (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  led_link_if.host        link,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_rw,
  input  wire logic [2:0] cmd_dev_sel,
  input  wire logic [7:0] cmd_ptr,
  input  wire logic [7:0] cmd_wdata,
  output logic            rsp_valid,
  output logic [7:0]      rsp_rdata,
  output logic            rsp_nack
);
  led_exp_pkg::host_reg_t q;
  led_exp_pkg::host_reg_t nxt;
  logic                   tick;
  logic [7:0]             cur;
  logic [7:0]             sh;

  assign tick = q.qcnt == `HOST_QTR_W'(`HOST_QTR_CYC - 1);

  // byte on the wire for the current slot; rx slot stays released
  always_comb
  begin
    case (q.bsel)
      `BSEL_ADDR_WR: cur = {`ADDR_FIXED, q.dsel, `RW_WRITE};
      `BSEL_PTR:     cur = q.ptr;
      `BSEL_DATA:    cur = q.wdata;
      `BSEL_ADDR_RD: cur = {`ADDR_FIXED, q.dsel, `RW_READ};
      default:       cur = 8'hFF;
    endcase
    sh = cur << q.bi;
  end

  // quarter-period sequencer; scl comes from our own divider
  always_comb
  begin
    nxt = q;
    nxt.sda_s1 = link.sda;
    nxt.sda_s2 = q.sda_s1;
    nxt.rsp_valid = 1'h0;
    if (q.st != led_exp_pkg::H_IDLE)
      nxt.qcnt = tick ? '0 : q.qcnt + 8'h01;
    if (q.st == led_exp_pkg::H_IDLE)
    begin
      // new transfer only from an idle bus
      if (cmd_valid && q.cmd_ready)
      begin
        nxt.cmd_ready = 1'h0;
        nxt.st = led_exp_pkg::H_START;
        nxt.ph = 2'h0;
        nxt.qcnt = '0;
        nxt.nack = 1'h0;
        nxt.rw = cmd_rw;
        nxt.dsel = cmd_dev_sel;
        nxt.ptr = cmd_ptr;
        nxt.wdata = cmd_wdata;
      end
    end
    else if (tick)
    begin
      nxt.ph = q.ph + 2'h1;
      case (q.st)
        // master makes start, stop and clock
        led_exp_pkg::H_START:
        begin
          if (q.ph == 2'h1)
            nxt.sda_oe = 1'h1;
          else if (q.ph == 2'h2)
          begin
            nxt.scl_oe = 1'h1;
            nxt.st = led_exp_pkg::H_BIT;
            nxt.ph = 2'h0;
            nxt.bi = 4'h0;
            nxt.bsel = `BSEL_ADDR_WR;
          end
        end
        led_exp_pkg::H_BIT:
        begin
          case (q.ph)
            2'h0: nxt.sda_oe = (q.bi < `BIT_LAST) && (q.bsel != `BSEL_RX) && !sh[7];
            2'h1: nxt.scl_oe = 1'h0;
            2'h2:
            begin
              if (q.bi < `BIT_LAST)
                nxt.rdata = {q.rdata[6:0], q.sda_s2};
              // high on the ninth clock is a refusal
              else if (q.bsel != `BSEL_RX && q.sda_s2)
                nxt.nack = 1'h1;
            end
            default:
            begin
              nxt.scl_oe = 1'h1;
              nxt.bi = q.bi + 4'h1;
              if (q.bi == `BIT_LAST)
              begin
                nxt.bi = 4'h0;
                nxt.bsel = q.bsel + 3'h1;
                if (q.nack || q.bsel == `BSEL_RX || q.bsel == `BSEL_DATA)
                  nxt.st = led_exp_pkg::H_STOP;
                else if (q.bsel == `BSEL_PTR && q.rw)
                  nxt.st = led_exp_pkg::H_RESTART;
              end
            end
          endcase
        end
        led_exp_pkg::H_RESTART:
        begin
          case (q.ph)
            2'h0: nxt.sda_oe = 1'h0;
            2'h1: nxt.scl_oe = 1'h0;
            2'h2: nxt.sda_oe = 1'h1;
            default:
            begin
              nxt.scl_oe = 1'h1;
              nxt.st = led_exp_pkg::H_BIT;
              nxt.bsel = `BSEL_ADDR_RD;
            end
          endcase
        end
        led_exp_pkg::H_STOP:
        begin
          case (q.ph)
            2'h0: nxt.sda_oe = 1'h1;
            2'h1: nxt.scl_oe = 1'h0;
            2'h2: nxt.sda_oe = 1'h0;
            default:
            begin
              nxt.st = led_exp_pkg::H_IDLE;
              nxt.rsp_valid = 1'h1;
              nxt.cmd_ready = 1'h1;
            end
          endcase
        end
        default: nxt.st = led_exp_pkg::H_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      q <= '{st: led_exp_pkg::H_IDLE, sda_s1: 1'h1, sda_s2: 1'h1, cmd_ready: 1'h1, default: '0};
    else
      q <= nxt;
  end

  assign link.scl_host_oe = q.scl_oe;
  assign link.sda_host_oe = q.sda_oe;
  assign cmd_ready = q.cmd_ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp_rdata = q.rdata;
  assign rsp_nack = q.nack;
endmodule
`default_nettype wire

// File: bench/led_link_checker.sv
// assertions on the two-wire link between host end and expander end
`timescale 1ns/100ps
`default_nettype none
module led_link_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_host_oe,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic       in_frame;
  logic [3:0] held;
  logic       start_ev;
  logic       stop_ev;

  // raw line events; the device sees them later, so raw framing leads it
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev  = scl && scl_q && !sda_q && sda;

  // frame tracking and count of clock falls under one device pull
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame <= 1'b0;
      held <= 4'h0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev)
        in_frame <= 1'b1;
      else if (stop_ev)
        in_frame <= 1'b0;
      if (!sda_dev_oe)
        held <= 4'h0;
      else if (scl_q && !scl)
        held <= held + 4'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !sda_dev_oe && !scl_host_oe && !sda_host_oe)
    else $error("link driven after reset");
  dev_change_low_a: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device moved data while clock high");
  frame_only_a: assert property ($rose(sda_dev_oe) |-> in_frame)
    else $error("device drove data outside a frame");
  pull_release_a: assert property (held <= 4'h9)
    else $error("device held data low too long");
  sync_lag_a: assert property ($fell(scl) |=> $stable(sda_dev_oe)[*8])
    else $error("device answered before synchronising");
  filter_lag_a: assert property ($changed(sda_dev_oe) |-> !$past(scl, 20))
    else $error("device answered inside the filter time");
  scl_low_min_a: assert property ($fell(scl) |=> !scl[*8])
    else $error("clock low period too short");
  start_free_a: assert property ($changed(sda_host_oe) && scl |-> !sda_dev_oe)
    else $error("start or stop on a held line");

  start_c: cover property (start_ev);
  stop_c: cover property (stop_ev);
  ack_c: cover property ($rose(sda_dev_oe));
endmodule
`default_nettype wire

// File: bench/test_led_expander_serial_slave_front.sv
// bench: host end and expander end joined over the link
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s expected %h seen %h", n, e, g); end end
module test_led_expander_serial_slave_front;
  typedef struct packed {
    logic        rw;
    logic [2:0]  sel;
    logic [7:0]  ptr;
    logic [7:0]  wd;
    logic [7:0]  rd;
    logic        nack;
    logic [15:0] oe;
  } row_t;
  logic        sys_clk     = 1'b0;
  logic        sys_rst     = 1'b1;
  logic        ext_reset_n = 1'b1;
  logic [2:0]  pin_sel     = 3'h5;
  logic        cmd_valid   = 1'b0;
  logic        cmd_rw      = 1'b0;
  logic [2:0]  cmd_dev_sel = 3'h0;
  logic [7:0]  cmd_ptr     = 8'h00;
  logic [7:0]  cmd_wdata   = 8'h00;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_rdata;
  logic        rsp_nack;
  logic [15:0] led_oe;
  logic [7:0]  rd;
  logic        nk;
  int          miscompares = 0;
  int          comparisons = 0;
  row_t        rows [4];

  led_link_if link();
  led_exp_host led_exp_host_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_rw(cmd_rw), .cmd_dev_sel(cmd_dev_sel), .cmd_ptr(cmd_ptr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
  // pins read back as open-drain levels: pulled low where driven
  led_exp_dev #(.BLINK_STEP_CYC(4)) led_exp_dev_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
    .ext_reset_n(ext_reset_n), .slave_select_pin_low(pin_sel[0]), .slave_select_pin_mid(pin_sel[1]),
    .slave_select_pin_high(pin_sel[2]), .open_drain_driver_pins_in(~led_oe),
    .open_drain_driver_pins_oe(led_oe));
  led_link_checker led_link_checker_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .scl_host_oe(link.scl_host_oe), .sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe),
    .scl(link.scl), .sda(link.sda));

  // 4 ns clock
  always #2 sys_clk = ~sys_clk;

  task end_of_test;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one command; held until taken, answer waited for under a bound
  task automatic issue(input row_t r);
    int n;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_rw = r.rw;
    cmd_dev_sel = r.sel;
    cmd_ptr = r.ptr;
    cmd_wdata = r.wd;
    for (n = 0; n < 1000 && cmd_ready !== 1'b1; n++)
      @(negedge sys_clk);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 40000 && rsp_valid !== 1'b1; n++)
      @(negedge sys_clk);
    `CHK("rsp_valid", 1'b1, rsp_valid)
    `CHK("cmd_ready", 1'b1, cmd_ready)
    rd = rsp_rdata;
    nk = rsp_nack;
  endtask

  // watchdog: four transfers need about 75000 cycles
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    end_of_test();
  end

  // table rows, then pin reset by hand
  initial
  begin
    rows[0] = '{1'b0, 3'h5, 8'h06, 8'h00, 8'h00, 1'b0, 16'h000F};
    rows[1] = '{1'b1, 3'h5, 8'h00, 8'h00, 8'hF0, 1'b0, 16'h000F};
    rows[2] = '{1'b0, 3'h2, 8'h06, 8'hAA, 8'h00, 1'b1, 16'h000F};
    // leds 6 and 7 on blinkers, still in the on phase of the default duty
    rows[3] = '{1'b0, 3'h5, 8'h07, 8'hE4, 8'h00, 1'b0, 16'h00DF};
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge sys_clk);
    foreach (rows[i])
    begin
      issue(rows[i]);
      `CHK("rsp_nack", rows[i].nack, nk)
      if (rows[i].rw)
        `CHK("rsp_rdata", rows[i].rd, rd)
      repeat (40) @(negedge sys_clk);
      `CHK("led_oe", rows[i].oe, led_oe)
    end
    ext_reset_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    `CHK("led_oe_in_reset", 16'h0000, led_oe)
    ext_reset_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    `CHK("led_oe_after_reset", 16'h0000, led_oe)
    end_of_test();
  end
endmodule
`default_nettype wire
